/* File: logic/ims_defines.svh */
// register map, field positions and reset values of the two-wire master sequencer
`ifndef IMS_DEFINES_SVH
`define IMS_DEFINES_SVH
`define IMS_ADDR_CTL      3'h0
`define IMS_ADDR_STAT     3'h1
`define IMS_ADDR_FLAGS    3'h2
`define IMS_ADDR_RELOAD   3'h3
`define IMS_ADDR_BUF      3'h4
`define IMS_REQ_START     0
`define IMS_REQ_RESTART   1
`define IMS_REQ_STOP      2
`define IMS_REQ_RECV      3
`define IMS_REQ_ACK       4
`define IMS_CTL_ACKVAL    5
`define IMS_CTL_ACKRX     6
`define IMS_REQ_NONE      5'h00
`define IMS_RELOAD_RST    8'h00
`define IMS_BYTE_RST      8'h00
`define IMS_BIT_FIRST     4'h0
`define IMS_BIT_LASTDATA  4'h7
`define IMS_BIT_ACK       4'h8
`define IMS_BIT_STEP      4'h1
`endif

/* File: logic/ims_pkg.sv */
// types shared by the two-wire master sequencer
package ims_pkg;
   typedef enum logic [4:0] {
      S_IDLE, S_ST_WAIT, S_ST_HOLD,
      S_RS_LOW, S_RS_SDA, S_RS_WAIT, S_RS_HI, S_RS_LO,
      S_BLOW, S_BWAIT, S_BHIGH,
      S_SP_LOW, S_SP_A, S_SP_WAIT, S_SP_B, S_SP_C
   } ims_state_type;
   typedef enum logic [1:0] {M_TX, M_RX, M_ACK} ims_mode_type;
   typedef struct packed {
      logic ovf;
      logic write_collision_flag;
      logic coll;
      logic ev;
   } ims_flags_type;
endpackage

/* File: logic/ims_master.sv */
// two-wire bus master sequencer: start, restart, byte tx/rx, ack and stop
`timescale 1ns/10ps
`default_nettype none
`include "ims_defines.svh"
module ims_master #(
   parameter int CW = 8
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [2:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   output var  logic [7:0] bus_rdata,
   input  wire logic       scl_i,
   output var  logic       scl_o,
   output var  logic       scl_oe,
   input  wire logic       sda_i,
   output var  logic       sda_o,
   output var  logic       sda_oe,
   output var  logic       event_o
);
   ims_pkg::ims_state_type st_q;
   ims_pkg::ims_mode_type  mode_q;
   ims_pkg::ims_flags_type flg_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] reload_q;
   logic [4:0]    req_q;
   logic [7:0]    buf_q;
   logic [7:0]    shift_q;
   logic [3:0]    bit_q;
   logic [7:0]    rdata_q;
   logic          ack_val_q, ack_rx_q, bf_q, scl_lo_q, sda_lo_q, sda_nxt_q;
   logic          scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q;
   logic          start_seen_q, stop_seen_q;
   logic          tmo, wr_ctl, wr_buf, idle;

   assign tmo    = (cnt_q == '0);
   assign wr_ctl = bus_wr && (bus_addr == `IMS_ADDR_CTL);
   assign wr_buf = bus_wr && (bus_addr == `IMS_ADDR_BUF);
   assign idle   = (st_q == ims_pkg::S_IDLE) && (req_q == `IMS_REQ_NONE);

   // open-drain pins: only ever pulled low
   assign scl_o     = 1'b0;
   assign sda_o     = 1'b0;
   assign scl_oe    = scl_lo_q;
   assign sda_oe    = sda_lo_q;
   assign event_o   = flg_q.ev;
   assign bus_rdata = rdata_q;

   // pin synchronisers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q} <= 5'h1F;
      end else begin
         {scl_s_q, scl_m_q} <= {scl_m_q, scl_i};
         {sda_p_q, sda_s_q, sda_m_q} <= {sda_s_q, sda_m_q, sda_i};
      end
   end

   // start and stop patterns seen on the lines
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {start_seen_q, stop_seen_q} <= 2'h0;
      end else if (scl_s_q && sda_p_q && !sda_s_q) begin
         start_seen_q <= 1'b1;
         stop_seen_q  <= 1'b0;
      end else if (scl_s_q && !sda_p_q && sda_s_q) begin
         start_seen_q <= 1'b0;
         stop_seen_q  <= 1'b1;
      end
   end

   // register read data, one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= `IMS_BYTE_RST;
      end else if (bus_rd) begin
         case (bus_addr)
            `IMS_ADDR_CTL:    rdata_q <= {1'b0, ack_rx_q, ack_val_q, req_q};
            `IMS_ADDR_STAT:   rdata_q <= {4'h0, ~idle, stop_seen_q, start_seen_q, bf_q};
            `IMS_ADDR_FLAGS:  rdata_q <= {4'h0, flg_q};
            `IMS_ADDR_RELOAD: rdata_q <= 8'(reload_q);
            `IMS_ADDR_BUF:    rdata_q <= buf_q;
            default:          rdata_q <= `IMS_BYTE_RST;
         endcase
      end
   end

   task automatic abort_seq();
      st_q     <= ims_pkg::S_IDLE;
      req_q    <= `IMS_REQ_NONE;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
      flg_q.coll <= 1'b1;
   endtask

   // sequencer; later assignments win, so hardware sets beat software clears
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q      <= ims_pkg::S_IDLE;
         mode_q    <= ims_pkg::M_TX;
         flg_q     <= '0;
         cnt_q     <= '0;
         reload_q  <= CW'(`IMS_RELOAD_RST);
         req_q     <= `IMS_REQ_NONE;
         buf_q     <= `IMS_BYTE_RST;
         shift_q   <= `IMS_BYTE_RST;
         bit_q     <= `IMS_BIT_FIRST;
         {ack_val_q, ack_rx_q, bf_q, scl_lo_q, sda_lo_q, sda_nxt_q} <= 6'h00;
      end else begin
         if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
         end
         if (bus_wr && bus_addr == `IMS_ADDR_FLAGS) begin
            flg_q <= flg_q & ~bus_wdata[3:0];
         end
         if (bus_wr && bus_addr == `IMS_ADDR_RELOAD) begin
            reload_q <= CW'(bus_wdata);
         end
         if (bus_rd && bus_addr == `IMS_ADDR_BUF) begin
            bf_q <= 1'b0;
         end
         if (wr_ctl) begin
            ack_val_q <= bus_wdata[`IMS_CTL_ACKVAL];
            if (idle) begin
               req_q <= bus_wdata[4:0];
            end
         end
         if (wr_buf) begin
            if (!idle) begin
               flg_q.write_collision_flag <= 1'b1;
            end else begin
               buf_q    <= bus_wdata;
               shift_q  <= bus_wdata;
               bf_q     <= 1'b1;
               mode_q   <= ims_pkg::M_TX;
               bit_q    <= `IMS_BIT_FIRST;
               scl_lo_q <= 1'b1;
               sda_nxt_q <= ~bus_wdata[7];
               cnt_q    <= reload_q;
               st_q     <= ims_pkg::S_BLOW;
            end
         end
         case (st_q)
            ims_pkg::S_IDLE: begin
               if (req_q[`IMS_REQ_START]) begin
                  if (!(scl_s_q && sda_s_q)) begin
                     abort_seq();
                  end else begin
                     cnt_q <= reload_q;
                     st_q  <= ims_pkg::S_ST_WAIT;
                  end
               end else if (req_q[`IMS_REQ_RESTART]) begin
                  scl_lo_q <= 1'b1;
                  st_q     <= ims_pkg::S_RS_LOW;
               end else if (req_q[`IMS_REQ_STOP]) begin
                  scl_lo_q <= 1'b1;
                  sda_lo_q <= 1'b1;
                  st_q     <= ims_pkg::S_SP_LOW;
               end else if (req_q[`IMS_REQ_RECV]) begin
                  mode_q   <= ims_pkg::M_RX;
                  bit_q    <= `IMS_BIT_FIRST;
                  scl_lo_q <= 1'b1;
                  sda_nxt_q <= 1'b0;
                  cnt_q    <= reload_q;
                  st_q     <= ims_pkg::S_BLOW;
               end else if (req_q[`IMS_REQ_ACK]) begin
                  mode_q   <= ims_pkg::M_ACK;
                  scl_lo_q <= 1'b1;
                  sda_nxt_q <= ~ack_val_q;
                  cnt_q    <= reload_q;
                  st_q     <= ims_pkg::S_BLOW;
               end
            end
            ims_pkg::S_ST_WAIT: begin
               if (!scl_s_q) begin
                  abort_seq();
               end else if (tmo) begin
                  if (sda_s_q) begin
                     sda_lo_q <= 1'b1;
                     cnt_q    <= reload_q;
                     st_q     <= ims_pkg::S_ST_HOLD;
                  end else begin
                     abort_seq();
                  end
               end
            end
            ims_pkg::S_ST_HOLD: begin
               if (tmo) begin
                  req_q[`IMS_REQ_START] <= 1'b0;
                  flg_q.ev <= 1'b1;
                  st_q     <= ims_pkg::S_IDLE;
               end
            end
            ims_pkg::S_RS_LOW: begin
               if (!scl_s_q) begin
                  sda_lo_q <= 1'b0;
                  cnt_q    <= reload_q;
                  st_q     <= ims_pkg::S_RS_SDA;
               end
            end
            ims_pkg::S_RS_SDA: begin
               if (tmo) begin
                  if (sda_s_q) begin
                     scl_lo_q <= 1'b0;
                     st_q     <= ims_pkg::S_RS_WAIT;
                  end else begin
                     abort_seq();
                  end
               end
            end
            ims_pkg::S_RS_WAIT: begin
               if (scl_s_q) begin
                  if (!sda_s_q) begin
                     abort_seq();
                  end else begin
                     cnt_q <= reload_q;
                     st_q  <= ims_pkg::S_RS_HI;
                  end
               end
            end
            ims_pkg::S_RS_HI: begin
               if (!scl_s_q || !sda_s_q) begin
                  abort_seq();
               end else if (tmo) begin
                  sda_lo_q <= 1'b1;
                  cnt_q    <= reload_q;
                  st_q     <= ims_pkg::S_RS_LO;
               end
            end
            ims_pkg::S_RS_LO: begin
               if (tmo) begin
                  scl_lo_q <= 1'b1;
                  req_q[`IMS_REQ_RESTART] <= 1'b0;
                  flg_q.ev <= 1'b1;
                  st_q     <= ims_pkg::S_IDLE;
               end
            end
            ims_pkg::S_BLOW: begin
               // data moves one cycle after the clock fell, never with it
               sda_lo_q <= sda_nxt_q;
               if (tmo) begin
                  scl_lo_q <= 1'b0;
                  st_q     <= ims_pkg::S_BWAIT;
               end
            end
            ims_pkg::S_BWAIT: begin
               if (scl_s_q) begin
                  cnt_q <= reload_q;
                  st_q  <= ims_pkg::S_BHIGH;
               end
            end
            ims_pkg::S_BHIGH: begin
               if (tmo) begin
                  scl_lo_q <= 1'b1;
                  cnt_q    <= reload_q;
                  bit_q    <= bit_q + `IMS_BIT_STEP;
                  st_q     <= ims_pkg::S_BLOW;
                  case (mode_q)
                     ims_pkg::M_TX: begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        if (bit_q == `IMS_BIT_ACK) begin
                           ack_rx_q <= sda_s_q;
                           flg_q.ev <= 1'b1;
                           st_q     <= ims_pkg::S_IDLE;
                        end else if (bit_q == `IMS_BIT_LASTDATA) begin
                           bf_q     <= 1'b0;
                           sda_nxt_q <= 1'b0;
                        end else begin
                           sda_nxt_q <= ~shift_q[6];
                        end
                     end
                     ims_pkg::M_RX: begin
                        shift_q <= {shift_q[6:0], sda_s_q};
                        if (bit_q == `IMS_BIT_LASTDATA) begin
                           req_q[`IMS_REQ_RECV] <= 1'b0;
                           buf_q    <= {shift_q[6:0], sda_s_q};
                           bf_q     <= 1'b1;
                           flg_q.ev <= 1'b1;
                           if (bf_q) begin
                              flg_q.ovf <= 1'b1;
                           end
                           st_q <= ims_pkg::S_IDLE;
                        end
                     end
                     default: begin
                        req_q[`IMS_REQ_ACK] <= 1'b0;
                        flg_q.ev <= 1'b1;
                        st_q     <= ims_pkg::S_IDLE;
                     end
                  endcase
               end
            end
            ims_pkg::S_SP_LOW: begin
               if (!sda_s_q) begin
                  cnt_q <= reload_q;
                  st_q  <= ims_pkg::S_SP_A;
               end
            end
            ims_pkg::S_SP_A: begin
               if (tmo) begin
                  scl_lo_q <= 1'b0;
                  st_q     <= ims_pkg::S_SP_WAIT;
               end
            end
            ims_pkg::S_SP_WAIT: begin
               if (scl_s_q) begin
                  cnt_q <= reload_q;
                  st_q  <= ims_pkg::S_SP_B;
               end
            end
            ims_pkg::S_SP_B: begin
               if (tmo) begin
                  sda_lo_q <= 1'b0;
                  cnt_q    <= reload_q;
                  st_q     <= ims_pkg::S_SP_C;
               end
            end
            ims_pkg::S_SP_C: begin
               if (tmo) begin
                  req_q[`IMS_REQ_STOP] <= 1'b0;
                  flg_q.ev <= 1'b1;
                  st_q     <= ims_pkg::S_IDLE;
               end
            end
            default: begin
               st_q <= ims_pkg::S_IDLE;
            end
         endcase
      end
   end

   // checks
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_start_load: assert property (st_q == ims_pkg::S_IDLE && req_q[`IMS_REQ_START]
      && scl_s_q && sda_s_q && !wr_buf |=> st_q == ims_pkg::S_ST_WAIT
      && cnt_q == reload_q) else $error("start did not load counter");
   a_start_edge: assert property (st_q == ims_pkg::S_ST_WAIT && tmo && scl_s_q
      && sda_s_q |=> sda_lo_q && !scl_lo_q) else $error("start edge missing");
   a_start_done: assert property (st_q == ims_pkg::S_ST_HOLD && tmo |=>
      !req_q[`IMS_REQ_START] && sda_lo_q && flg_q.ev) else $error("start end wrong");
   a_start_coll: assert property (st_q == ims_pkg::S_IDLE && req_q[`IMS_REQ_START]
      && !scl_s_q && !sda_s_q |=> flg_q.coll && st_q == ims_pkg::S_IDLE
      && !scl_lo_q) else $error("start collision missed");
   a_restart_ign: assert property (wr_ctl && !idle && !req_q[`IMS_REQ_RESTART]
      |=> !req_q[`IMS_REQ_RESTART]) else $error("restart taken while busy");
   a_restart_end: assert property (st_q == ims_pkg::S_RS_LO && tmo |=> scl_lo_q
      && sda_lo_q && flg_q.ev && !req_q[`IMS_REQ_RESTART]) else $error("restart end wrong");
   a_write_collision_flag_keep: assert property (wr_buf && !idle |=> flg_q.write_collision_flag
      && buf_q == $past(buf_q)) else $error("busy write not refused");
   a_ack_capture: assert property (st_q == ims_pkg::S_BHIGH && tmo
      && mode_q == ims_pkg::M_TX && bit_q == `IMS_BIT_ACK |=> ack_rx_q == $past(sda_s_q)
      && st_q == ims_pkg::S_IDLE && scl_lo_q) else $error("ack not captured");
   a_rx_ovf: assert property (st_q == ims_pkg::S_BHIGH && tmo && mode_q == ims_pkg::M_RX
      && bit_q == `IMS_BIT_LASTDATA && bf_q |=> flg_q.ovf && bf_q) else $error("overflow missed");

   c_start: cover property (st_q == ims_pkg::S_ST_HOLD && tmo);
   c_tx_byte: cover property (mode_q == ims_pkg::M_TX && bit_q == `IMS_BIT_ACK && tmo
      && st_q == ims_pkg::S_BHIGH);
   c_rx_byte: cover property (mode_q == ims_pkg::M_RX && bit_q == `IMS_BIT_LASTDATA && tmo
      && st_q == ims_pkg::S_BHIGH);
   c_stop: cover property (st_q == ims_pkg::S_SP_C && tmo);
endmodule
`default_nettype wire

/* File: testbench/ims_slave_model.sv */
// behavioural two-wire slave: address match, ack or nack, read data, clock stretch
`timescale 1ns/10ps
`default_nettype none
module ims_slave_model #(
   parameter logic [6:0] ADDR = 7'h52
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       nack,
   input  wire logic       stretch,
   input  wire logic [7:0] tx_byte,
   output var  logic       scl_low,
   output var  logic       sda_low,
   output var  logic [7:0] rx_byte,
   output var  logic       ack_seen
);
   int         bitc = 0;
   logic [7:0] sh   = 8'h00;
   logic       act  = 1'b0;
   logic       adr  = 1'b0;
   logic       rdm  = 1'b0;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      rx_byte = 8'h00;
      ack_seen = 1'b0;
   end
   // start or repeated start restarts the byte count
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         bitc = 0;
         act = 1'b1;
         adr = 1'b1;
         rdm = 1'b0;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1)
         act = 1'b0;
   end
   always @(posedge scl) begin
      if (act && bitc < 8)
         sh = {sh[6:0], sda};
      else if (act && rdm)
         ack_seen = sda;
      if (act)
         bitc = bitc + 1;
   end
   // data changes only while the clock is low
   always @(negedge scl) begin
      if (act && bitc == 8) begin
         rx_byte = sh;
         if (adr)
            rdm = (sh[7:1] == ADDR) && sh[0];
         sda_low = (adr || !rdm) && !nack;
         adr = 1'b0;
      end else if (act && bitc == 9) begin
         bitc = 0;
         sda_low = rdm && !ack_seen && !tx_byte[7];
      end else if (act && rdm && bitc > 0)
         sda_low = !tx_byte[7 - bitc];
   end
   // slow device: holds the clock low after each fall
   always @(negedge scl) begin
      if (act && stretch) begin
         scl_low = 1'b1;
         #600;
         scl_low = 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the two-wire master sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ims_defines.svh"
module tb;
   localparam logic [7:0] RLD  = 8'h03;
   localparam int         T    = 4;
   localparam logic [6:0] SADR = 7'h52;
   logic        clk_sys, rst, bus_wr, bus_rd, scl_oe, sda_oe, event_o;
   logic        sl_scl, sl_sda, tb_scl, tb_sda, nack, stretch, ack_seen, rd_d;
   logic [2:0]  bus_addr;
   logic [7:0]  bus_wdata, bus_rdata, rx_byte, tx_byte, d;
   logic [7:0]  exp_q[$], msk_q[$];
   string       nam_q[$];
   logic [31:0] seed;
   int          err_count, total_checks, n;
   wire logic   scl = !(scl_oe || sl_scl || tb_scl);
   wire logic   sda = !(sda_oe || sl_sda || tb_sda);
   ims_master #(.CW(8)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .scl_i(scl),
      .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
      .event_o(event_o));
   ims_slave_model #(.ADDR(SADR)) sl_u (
      .scl(scl), .sda(sda), .nack(nack), .stretch(stretch), .tx_byte(tx_byte),
      .scl_low(sl_scl), .sda_low(sl_sda), .rx_byte(rx_byte), .ack_seen(ack_seen));
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
                     input string nm);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      nam_q.push_back(nm);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
   endtask
   task automatic wait_ev();
      int i;
      for (i = 0; i < 3000; i++) begin
         @(posedge clk_sys);
         if (event_o === 1'b1)
            break;
      end
      if (i == 3000) begin
         chk("event wait", 8'h01, 8'h00);
         test_done();
      end
   endtask
   // read data are checked in the cycle after the strobe
   always @(posedge clk_sys) begin
      if (rd_d === 1'b1 && exp_q.size() > 0)
         chk(nam_q.pop_front(), exp_q.pop_front(), bus_rdata & msk_q.pop_front());
      rd_d <= bus_rd;
   end
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      {rst, bus_wr, bus_rd, bus_addr, bus_wdata} = {1'b1, 13'h0000};
      {tb_scl, tb_sda, nack, stretch, rd_d, tx_byte} = {5'h00, 8'h00};
      {seed, err_count, total_checks, d} = {32'd95, 64'd0, 8'h00};
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      for (n = 0; n < 6; n++)
         rd(n[2:0], (n == 0) ? 8'h3F : 8'hFF, 8'h00, "reset value");
      wr(3'h5, 8'hFF);
      rd(3'h5, 8'hFF, 8'h00, "unmapped");
      wr(`IMS_ADDR_RELOAD, RLD);
      rd(`IMS_ADDR_RELOAD, 8'hFF, RLD, "reload");
      $display("test registers done");
      wr(`IMS_ADDR_CTL, 8'h01);
      for (n = 0; n < 40 && sda_oe !== 1'b1; n++)
         @(posedge clk_sys);
      chk("start delay", 8'h01, {7'h00, n >= T && n <= T + 3});
      chk("clock high at start edge", 8'h00, {7'h00, scl_oe});
      wait_ev();
      rd(`IMS_ADDR_STAT, 8'h02, 8'h02, "start seen");
      rd(`IMS_ADDR_CTL, 8'h1F, 8'h00, "start cleared");
      rd(`IMS_ADDR_FLAGS, 8'h0F, 8'h01, "start event");
      chk("data held low", 8'h01, {7'h00, sda_oe});
      wr(`IMS_ADDR_FLAGS, 8'h0F);
      $display("test start done");
      wr(`IMS_ADDR_BUF, {SADR, 1'b0});
      rd(`IMS_ADDR_STAT, 8'h01, 8'h01, "buffer full");
      wr(`IMS_ADDR_BUF, 8'h5A);
      wr(`IMS_ADDR_CTL, 8'h0A);
      wait_ev();
      rd(`IMS_ADDR_CTL, 8'h5F, 8'h00, "ack and requests");
      rd(`IMS_ADDR_STAT, 8'h01, 8'h00, "buffer emptied");
      rd(`IMS_ADDR_BUF, 8'hFF, {SADR, 1'b0}, "buffer kept");
      rd(`IMS_ADDR_FLAGS, 8'h0F, 8'h05, "event and write_collision_flag");
      chk("clock held low", 8'h01, {7'h00, scl_oe});
      chk("address on wire", {SADR, 1'b0}, rx_byte);
      wr(`IMS_ADDR_FLAGS, 8'h0F);
      for (n = 0; n < 2; n++) begin
         nack <= n[0];
         stretch <= n[0];
         d = rnd();
         wr(`IMS_ADDR_BUF, d);
         wait_ev();
         rd(`IMS_ADDR_CTL, 8'h40, {1'b0, n[0], 6'h00}, "ack received");
         chk("data on wire", d, rx_byte);
         wr(`IMS_ADDR_FLAGS, 8'h0F);
      end
      $display("test transmit done");
      nack <= 1'b0;
      stretch <= 1'b0;
      wr(`IMS_ADDR_CTL, 8'h02);
      wait_ev();
      rd(`IMS_ADDR_STAT, 8'h02, 8'h02, "restart seen");
      rd(`IMS_ADDR_CTL, 8'h1F, 8'h00, "restart cleared");
      chk("restart lines", 8'h03, {6'h00, scl_oe, sda_oe});
      wr(`IMS_ADDR_FLAGS, 8'h0F);
      $display("test restart done");
      tx_byte <= rnd();
      wr(`IMS_ADDR_BUF, {SADR, 1'b1});
      wait_ev();
      wr(`IMS_ADDR_FLAGS, 8'h0F);
      wr(`IMS_ADDR_CTL, 8'h08);
      wait_ev();
      rd(`IMS_ADDR_STAT, 8'h01, 8'h01, "rx full");
      rd(`IMS_ADDR_CTL, 8'h1F, 8'h00, "receive cleared");
      chk("rx clock held", 8'h01, {7'h00, scl_oe});
      d = rnd();
      tx_byte <= d;
      wr(`IMS_ADDR_FLAGS, 8'h0F);
      wr(`IMS_ADDR_CTL, 8'h10);
      wait_ev();
      chk("ack value sent", 8'h00, {7'h00, ack_seen});
      wr(`IMS_ADDR_FLAGS, 8'h0F);
      wr(`IMS_ADDR_CTL, 8'h08);
      wait_ev();
      rd(`IMS_ADDR_FLAGS, 8'h08, 8'h08, "overflow");
      rd(`IMS_ADDR_BUF, 8'hFF, d, "received byte");
      rd(`IMS_ADDR_STAT, 8'h01, 8'h00, "read clears full");
      wr(`IMS_ADDR_FLAGS, 8'h0F);
      wr(`IMS_ADDR_CTL, 8'h30);
      wait_ev();
      chk("nack value sent", 8'h01, {7'h00, ack_seen});
      wr(`IMS_ADDR_FLAGS, 8'h0F);
      $display("test receive done");
      wr(`IMS_ADDR_CTL, 8'h04);
      wait_ev();
      rd(`IMS_ADDR_STAT, 8'h04, 8'h04, "stop seen");
      chk("stop release", 8'h00, {6'h00, scl_oe, sda_oe});
      wr(`IMS_ADDR_FLAGS, 8'h0F);
      $display("test stop done");
      for (n = 0; n < 2; n++) begin
         tb_scl <= !n[0];
         tb_sda <= n[0];
         repeat (4) @(posedge clk_sys);
         wr(`IMS_ADDR_CTL, n[0] ? 8'h02 : 8'h01);
         repeat (6 * T + 8) @(posedge clk_sys);
         rd(`IMS_ADDR_FLAGS, 8'h02, 8'h02, "collision");
         rd(`IMS_ADDR_CTL, 8'h1F, 8'h00, "collision abort");
         chk("collision release", 8'h00, {6'h00, scl_oe, sda_oe});
         tb_scl <= 1'b0;
         tb_sda <= 1'b0;
         wr(`IMS_ADDR_FLAGS, 8'h0F);
      end
      $display("test collision done");
      repeat (3) @(posedge clk_sys);
      test_done();
   end
endmodule
`default_nettype wire
